// *** dv/fbm_checker.sv ***
// assertions on the fieldbus slave bit mapper ports
`timescale 1ns/10ps
`default_nettype none
module fbm_checker (
  input wire pclk,
  input wire presetn,
  input wire fb_req,
  input wire [5:0] fb_addr,
  input wire fb_prm_req,
  input wire [3:0] fb_prm,
  input wire fb_rsp_valid,
  input wire fb_prm_rsp_valid,
  input wire [3:0] fb_prm_rsp,
  input wire [3:0] drv_alarm_code,
  input wire [3:0] drv_fault_code,
  input wire fault_ack,
  input wire slave1_active,
  input wire slave2_visible
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_diag;
    fb_req && fb_prm_req ##1 fb_rsp_valid;
  endsequence
  sequence s_fault;
    fb_req && fb_prm_req && fb_prm[0] ##1 fb_rsp_valid;
  endsequence
  sequence s_alarm;
    fb_req && fb_prm_req && !fb_prm[0] ##1 fb_rsp_valid;
  endsequence
  chk_zero_silent: assert property (fb_req && fb_addr == 6'h00 |=> !fb_rsp_valid)
    else $error("slave at address zero answered");
  chk_rsp_cause: assert property (fb_rsp_valid |-> $past(fb_req))
    else $error("answer without a frame");
  chk_prm_pair: assert property (fb_prm_rsp_valid |-> fb_rsp_valid)
    else $error("parameter answer outside a frame answer");
  chk_diag_answer: assert property (s_diag |-> fb_prm_rsp_valid)
    else $error("diagnostic request not answered");
  chk_fault_code: assert property (s_fault |-> fb_prm_rsp == $past(drv_fault_code))
    else $error("wrong fault code");
  chk_alarm_code: assert property (s_alarm |-> fb_prm_rsp == $past(drv_alarm_code))
    else $error("wrong alarm code");
  chk_s2_hidden: assert property (slave2_visible |-> slave1_active)
    else $error("second slave shown early");
  chk_ack_pulse: assert property (fault_ack |=> !fault_ack)
    else $error("acknowledge longer than one cycle");
  chk_ack_cause: assert property (fault_ack |-> $past(fb_req))
    else $error("acknowledge without a frame");
endmodule
bind fbm_bit_mapper fbm_checker u_chk (.*);
`default_nettype wire

// *** dv/fbm_master_model.sv ***
// fieldbus master model: frames and automatic address assignment
`timescale 1ns/10ps
`default_nettype none
module fbm_master_model (
  input wire logic pclk,
  output logic fb_req,
  output logic [5:0] fb_addr,
  output logic [3:0] fb_do,
  output logic fb_prm_req,
  output logic [3:0] fb_prm,
  output logic fb_assign,
  output logic [5:0] fb_assign_addr
);
  initial begin
    fb_req = 1'b0;
    fb_addr = 6'h2A;
    fb_do = 4'h5;
    fb_prm_req = 1'b0;
    fb_prm = 4'hA;
    fb_assign = 1'b0;
    fb_assign_addr = 6'h15;
  end
  // released address, data and parameter fields show the inverse of their last value; both request strobes drop to 0
  task automatic frame(input logic [5:0] a, input logic [3:0] d, input logic pr, input logic [3:0] pv);
    @(posedge pclk);
    fb_req <= 1'b1;
    fb_addr <= a;
    fb_do <= d;
    fb_prm_req <= pr;
    fb_prm <= pv;
    @(posedge pclk);
    fb_req <= 1'b0;
    fb_addr <= ~a;
    fb_do <= ~d;
    fb_prm_req <= 1'b0;
    fb_prm <= ~pv;
  endtask
  // only called while at least one slave sits at address 0
  task automatic assign_addr(input logic [5:0] a);
    @(posedge pclk);
    fb_assign <= 1'b1;
    fb_assign_addr <= a;
    @(posedge pclk);
    fb_assign <= 1'b0;
    fb_assign_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// *** dv/fieldbus_slave_bit_mapper_test.sv ***
// self-checking bench of the fieldbus slave bit mapper
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.vh"
module fieldbus_slave_bit_mapper_test;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] local_in, drv_alarm_code, drv_fault_code;
  logic drv_op_enable, drv_pulses_en, drv_ready_on, drv_ctrl_prio;
  wire [31:0] prdata;
  wire pready, pslverr, fb_req, fb_prm_req, fb_assign, fb_rsp_valid, fb_prm_rsp_valid;
  wire [5:0] fb_addr, fb_assign_addr;
  wire [3:0] fb_do, fb_prm, fb_rsp_di, fb_prm_rsp, fixed_speed_sel, scaling_code;
  wire run_cw, run_ccw, setpoint_ai, op_enable_grant, fault_ack, quick_stop_ovr;
  wire slave1_active, slave2_visible, run_on, coast_stop;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  fbm_bit_mapper dut (.*);
  fbm_master_model m (.*);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frm(input logic [5:0] a, input logic [3:0] d, input logic pr, input logic [3:0] pv);
    m.frame(a, d, pr, pv);
    #1;
  endtask
  task automatic t_reset;
    apb(0, `FBM_OFF_MODE, 0);
    chk("mode", rd, 32'h0);
    apb(0, `FBM_OFF_ADDR, 0);
    chk("addr", rd, 32'h0);
    frm(6'h00, 4'hF, 0, 4'h0);
    chk("rsp0", fb_rsp_valid, 1'b0);
    apb(0, 12'h0FC, 0);
    chk("unmapped", err, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_single;
    drv_op_enable <= 1'b1;
    apb(1, `FBM_OFF_PRESET, 32'h1E);
    apb(0, `FBM_OFF_MODE, 0);
    chk("mode30", rd, 32'h0);
    m.assign_addr(6'h07);
    apb(0, `FBM_OFF_ADDR, 0);
    chk("auto", rd[13:8], 6'h07);
    apb(1, `FBM_OFF_ADDR, 32'h2800);
    apb(0, `FBM_OFF_ADDR, 0);
    chk("range", rd[13:8], 6'h07);
    frm(6'h07, 4'hB, 1, 4'h1);
    chk("valid", fb_rsp_valid, 1'b1);
    chk("speed", fixed_speed_sel, 4'hB);
    chk("di30", fb_rsp_di, 4'h5);
    chk("fault", fb_prm_rsp, 4'h4);
    apb(1, `FBM_OFF_ADDR, 32'h0900);
    frm(6'h09, 4'h0, 0, 4'h0);
    chk("newaddr", fb_rsp_valid, 1'b1);
    $display("single test done");
  endtask
  task automatic t_p32;
    drv_ready_on <= 1'b1;
    drv_ctrl_prio <= 1'b0;
    apb(1, `FBM_OFF_PRESET, 32'h20);
    frm(6'h09, 4'h1, 0, 4'h0);
    chk("cw", {run_cw, run_ccw}, 2'b10);
    chk("di32", fb_rsp_di, 4'h5);
    frm(6'h09, 4'h2, 0, 4'h0);
    chk("ccw", {run_cw, run_ccw}, 2'b01);
    frm(6'h09, 4'h4, 0, 4'h0);
    chk("ai", setpoint_ai, 1'b1);
    frm(6'h09, 4'h8, 1, 4'h6);
    chk("ack", fault_ack, 1'b1);
    chk("grant", op_enable_grant, 1'b1);
    chk("scale", scaling_code, 4'h6);
    chk("alarm", fb_prm_rsp, 4'h3);
    frm(6'h09, 4'h8, 0, 4'h0);
    chk("ack2", fault_ack, 1'b0);
    $display("preset 32 test done");
  endtask
  task automatic t_dual;
    apb(1, `FBM_OFF_PRESET, 32'h1F);
    apb(0, `FBM_OFF_MODE, 0);
    chk("mode31", rd, 32'h2);
    apb(1, `FBM_OFF_ADDR, 0);
    chk("hidden", slave2_visible, 1'b0);
    m.assign_addr(6'h03);
    #1;
    chk("shown", slave2_visible, 1'b1);
    m.assign_addr(6'h23);
    apb(0, `FBM_OFF_ADDR, 0);
    chk("addrs", rd, 32'h2303);
    frm(6'h23, 4'hD, 0, 4'h0);
    chk("speed31", fixed_speed_sel, 4'h5);
    frm(6'h03, 4'h4, 0, 4'h0);
    chk("qstop", quick_stop_ovr, 1'b1);
    chk("di_s1", fb_rsp_di[1:0], 2'b10);
    apb(1, `FBM_OFF_PRESET, 32'h1E);
    apb(1, `FBM_OFF_PRESET, 32'h22);
    apb(0, `FBM_OFF_MODE, 0);
    chk("mode34", rd, 32'h2);
    frm(6'h23, 4'hB, 0, 4'h0);
    chk("on_coast", {run_on, coast_stop, fault_ack}, 3'b110);
    frm(6'h23, 4'h4, 0, 4'h0);
    chk("ack34", fault_ack, 1'b1);
    $display("dual test done");
  endtask
  task automatic t_serial;
    logic [31:0] w;
    w = 32'hA5C3_0F96;
    for (int i = 31; i >= 0; i--) begin
      frm(6'h03, {2'b00, w[i], 1'b0}, 0, 4'h0);
      frm(6'h03, {2'b00, w[i], 1'b1}, 0, 4'h0);
    end
    apb(0, `FBM_OFF_SER_RX, 0);
    chk("ser_rx", rd, 32'hA5C3_0F96);
    apb(0, `FBM_OFF_STAT, 0);
    chk("rx_done", rd[0], 1'b1);
    apb(1, `FBM_OFF_STAT, 32'h1);
    apb(0, `FBM_OFF_STAT, 0);
    chk("rx_clr", rd[0], 1'b0);
    $display("serial test done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    local_in = 4'h9;
    drv_op_enable = 1'b0;
    drv_pulses_en = 1'b0;
    drv_ready_on = 1'b0;
    drv_ctrl_prio = 1'b1;
    drv_alarm_code = 4'h3;
    drv_fault_code = 4'h4;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_single;
    t_p32;
    t_dual;
    t_serial;
    end_sim;
  end
endmodule
`default_nettype wire

// *** hdl/fbm_bit_mapper.v ***
// fieldbus slave bit mapper: addressing, command decode, response build and apb registers
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.vh"

// Operation
// - both slave addresses reset to 0; a slave at 0 answers no cyclic frame
// - mode 0 selects single-address, 2 dual-address; 0 after reset
// - preset 30 or 32 forces single mode, preset 31 or 34 forces dual mode
// - mode and address writes act on the next frame, no commit needed
// - single mode automatic assignment to the slave at 0 is stored in the setting
// - dual mode hides slave 2 until slave 1 has a valid address; only slave2_visible stays low, slave 2 still answers at its address
// - single mode uses address element 1, A-type, range 0 to 31
// - dual mode: element 0 slave 1, element 1 slave 2; 33..63 are B addresses
// - single mode carries four process bits each way plus diagnostic parameter
// - preset 30 output bits 0..3 form the fixed-speed selector
// - presets 30, 31 return enable, pulses, local inputs 0 and 1
// - diagnostic request returns pending fault or alarm code on parameter response
// - preset 32 bits 0..2: run clockwise, run counter-clockwise, analog setpoint
// - preset 32 bit 3 rising edge acknowledges faults, level grants enable
// - preset 32 returns ready, control priority, local inputs 0 and 1
// - preset 32 parameter write loads speed scaling code and answers diagnostics
// - dual mode carries eight process bits across two slaves plus diagnostics
// - preset 31 slave 2 bits 0..2 form a three-bit fixed-speed selector
// - dual mode output bit 3 selects slave A or B, never a command
// - slave 1 runs a 32-bit serial parameter channel on output bits 0, 1 and response bits 2, 3
// - preset 31 slave 1 bit 2 is quick-stop override; returns local inputs 2, 3
// - preset 34 slave 2 takes drive commands; slave 1 quick stop and serial data
module fbm_bit_mapper (
  input wire pclk,
  input wire presetn,

  // register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,

  // frames from the bus layer
  input wire fb_req,
  input wire [5:0] fb_addr,
  input wire [3:0] fb_do,
  input wire fb_prm_req,
  input wire [3:0] fb_prm,
  input wire fb_assign,
  input wire [5:0] fb_assign_addr,

  // answers to the bus layer
  output reg fb_rsp_valid,
  output reg [3:0] fb_rsp_di,
  output reg fb_prm_rsp_valid,
  output reg [3:0] fb_prm_rsp,

  // local pins and drive status
  input wire [3:0] local_in,
  input wire drv_op_enable,
  input wire drv_pulses_en,
  input wire drv_ready_on,
  input wire drv_ctrl_prio,
  input wire [3:0] drv_alarm_code,
  input wire [3:0] drv_fault_code,

  // drive commands
  output reg [3:0] fixed_speed_sel,
  output reg run_cw,
  output reg run_ccw,
  output reg setpoint_ai,
  output reg op_enable_grant,
  output reg fault_ack,
  output reg run_on,
  output reg coast_stop,
  output reg quick_stop_ovr,
  output reg [3:0] scaling_code,

  // addressing status
  output wire slave1_active,
  output wire slave2_visible
);

  reg [3:0] loc_meta_q;
  reg [3:0] loc_q;
  reg [1:0] mode_q;
  reg [7:0] preset_q;
  reg [5:0] addr0_q;
  reg [5:0] addr1_q;
  reg [31:0] ser_tx_q;
  reg [31:0] ser_rx_q;
  reg [31:0] rx_sh_q;
  reg [31:0] tx_sh_q;
  reg [5:0] ser_cnt_q;
  reg ser_mclk_q;
  reg rx_done_q;
  reg ack_lvl_q;

  wire dual;
  wire hit_s;
  wire hit1;
  wire hit2;
  wire wr;
  wire setup;
  wire mclk_rise;
  wire [5:0] wa0;
  wire [5:0] wa1;

  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign dual = (mode_q == `FBM_MODE_DUAL);
  assign wa0 = pwdata[`FBM_ADDR0_LSB+5:`FBM_ADDR0_LSB];
  assign wa1 = pwdata[`FBM_ADDR1_LSB+5:`FBM_ADDR1_LSB];

  // a slave at address 0 takes no part in cyclic exchange
  assign hit_s = fb_req & ~dual & (addr1_q != 6'h00) & (fb_addr == addr1_q);
  assign hit1 = fb_req & dual & (addr0_q != 6'h00) & (fb_addr == addr0_q);
  assign hit2 = fb_req & dual & (addr1_q != 6'h00) & (fb_addr == addr1_q);
  assign slave1_active = dual ? (addr0_q != 6'h00) : (addr1_q != 6'h00);
  // second slave stays hidden while the first still sits at 0
  assign slave2_visible = dual & (addr0_q != 6'h00);
  assign mclk_rise = hit1 & fb_do[0] & ~ser_mclk_q;

  // local input pins cross into pclk through two flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_meta_q <= 4'h0;
    end else begin
      loc_meta_q <= local_in;
    end
  end

  // only this second stage reads the first flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_q <= 4'h0;
    end else begin
      loc_q <= loc_meta_q;
    end
  end

  // mode, preset and serial transmit word settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `FBM_RST_MODE;
      preset_q <= `FBM_RST_PRESET;
      ser_tx_q <= 32'h0000_0000;
    end else begin
      // mode writes other than single or dual are ignored
      if (wr && paddr == `FBM_OFF_MODE) begin
        if (pwdata[1:0] == `FBM_MODE_SINGLE || pwdata[1:0] == `FBM_MODE_DUAL) begin
          mode_q <= pwdata[1:0];
        end
      end else if (wr && paddr == `FBM_OFF_PRESET) begin
        preset_q <= pwdata[7:0];
        if (pwdata[7:0] == `FBM_PRESET_30 || pwdata[7:0] == `FBM_PRESET_32) begin
          mode_q <= `FBM_MODE_SINGLE;
        end else if (pwdata[7:0] == `FBM_PRESET_31 || pwdata[7:0] == `FBM_PRESET_34) begin
          mode_q <= `FBM_MODE_DUAL;
        end
      end else if (wr && paddr == `FBM_OFF_SER_TX) begin
        ser_tx_q <= pwdata;
      end
    end
  end

  // slave address settings, from software or from the master's assignment
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr0_q <= `FBM_RST_ADDR;
      addr1_q <= `FBM_RST_ADDR;
    end else begin
      // a master assignment wins over a software write in the same cycle
      if (fb_assign) begin
        if (!dual) begin
          if (addr1_q == 6'h00 && fb_assign_addr <= `FBM_ADDR_A_MAX) begin
            addr1_q <= fb_assign_addr;
          end
        end else if (addr0_q == 6'h00) begin
          if (fb_assign_addr != `FBM_ADDR_BAD) begin
            addr0_q <= fb_assign_addr;
          end
        end else if (addr1_q == 6'h00) begin
          if (fb_assign_addr != `FBM_ADDR_BAD) begin
            addr1_q <= fb_assign_addr;
          end
        end
      end else if (wr && paddr == `FBM_OFF_ADDR) begin
        if (!dual) begin
          if (wa1 <= `FBM_ADDR_A_MAX) begin
            addr1_q <= wa1;
          end
        end else begin
          if (wa0 != `FBM_ADDR_BAD) begin
            addr0_q <= wa0;
          end
          if (wa1 != `FBM_ADDR_BAD) begin
            addr1_q <= wa1;
          end
        end
      end
    end
  end

  // output bits of addressed frames become drive commands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_speed_sel <= 4'h0;
      run_cw <= 1'b0;
      run_ccw <= 1'b0;
      setpoint_ai <= 1'b0;
      op_enable_grant <= 1'b0;
      fault_ack <= 1'b0;
      run_on <= 1'b0;
      coast_stop <= 1'b0;
      quick_stop_ovr <= 1'b0;
      ack_lvl_q <= 1'b0;
    end else begin
      fault_ack <= 1'b0;
      if (hit_s && preset_q == `FBM_PRESET_30) begin
        fixed_speed_sel <= fb_do;
      end else if (hit_s && preset_q == `FBM_PRESET_32) begin
        run_cw <= fb_do[0];
        run_ccw <= fb_do[1];
        setpoint_ai <= fb_do[2];
        op_enable_grant <= fb_do[3];
        fault_ack <= fb_do[3] & ~ack_lvl_q;
        ack_lvl_q <= fb_do[3];
      end
      // bit 3 of either dual slave is the A/B select and is never decoded
      if (hit2 && preset_q == `FBM_PRESET_31) begin
        fixed_speed_sel <= {1'b0, fb_do[2:0]};
      end else if (hit2 && preset_q == `FBM_PRESET_34) begin
        run_on <= fb_do[0];
        coast_stop <= fb_do[1];
        fault_ack <= fb_do[2] & ~ack_lvl_q;
        ack_lvl_q <= fb_do[2];
      end
      if (hit1 && (preset_q == `FBM_PRESET_31 || preset_q == `FBM_PRESET_34)) begin
        quick_stop_ovr <= fb_do[2];
      end
    end
  end

  // last transfer clock level seen on slave 1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_mclk_q <= 1'b0;
    end else if (hit1) begin
      ser_mclk_q <= fb_do[0];
    end
  end

  // bit-serial parameter channel on slave 1, msb first, 32 bits a word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= 32'h0000_0000;
      tx_sh_q <= 32'h0000_0000;
      ser_cnt_q <= 6'h00;
      ser_rx_q <= 32'h0000_0000;
      rx_done_q <= 1'b0;
    end else begin
      // a finished word in the same cycle wins over the clear
      if (wr && paddr == `FBM_OFF_STAT && pwdata[`FBM_STAT_RXDONE]) begin
        rx_done_q <= 1'b0;
      end
      if (mclk_rise) begin
        rx_sh_q <= {rx_sh_q[30:0], fb_do[1]};
        if (ser_cnt_q == `FBM_SER_BITS - 6'h01) begin
          ser_cnt_q <= 6'h00;
          ser_rx_q <= {rx_sh_q[30:0], fb_do[1]};
          rx_done_q <= 1'b1;
          tx_sh_q <= ser_tx_q;
        end else begin
          ser_cnt_q <= ser_cnt_q + 6'h01;
          if (ser_cnt_q == 6'h00) begin
            tx_sh_q <= {ser_tx_q[30:0], 1'b0};
          end else begin
            tx_sh_q <= {tx_sh_q[30:0], 1'b0};
          end
        end
      end
    end
  end

  // answer strobes, one cycle after the frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_rsp_valid <= 1'b0;
      fb_prm_rsp_valid <= 1'b0;
    end else begin
      fb_rsp_valid <= hit_s | hit1 | hit2;
      fb_prm_rsp_valid <= fb_prm_req & (hit_s | hit1 | hit2);
    end
  end

  // response bits of the addressed slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_rsp_di <= 4'h0;
    end else begin
      if (hit_s && preset_q == `FBM_PRESET_32) begin
        fb_rsp_di <= {loc_q[1], loc_q[0], drv_ctrl_prio, drv_ready_on};
      end else if (hit_s || hit2) begin
        fb_rsp_di <= {loc_q[1], loc_q[0], drv_pulses_en, drv_op_enable};
      end else if (hit1) begin
        fb_rsp_di <= {ser_mclk_q, tx_sh_q[31], loc_q[3], loc_q[2]};
      end
    end
  end

  // diagnostic answer and speed scaling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_prm_rsp <= 4'h0;
      scaling_code <= 4'h0;
    end else begin
      if (fb_prm_req && (hit_s || hit1 || hit2)) begin
        // parameter bit 0 chooses fault codes over alarm codes
        fb_prm_rsp <= fb_prm[0] ? drv_fault_code : drv_alarm_code;
        if (hit_s && preset_q == `FBM_PRESET_32) begin
          scaling_code <= fb_prm;
        end
      end
    end
  end

  // apb read mux; data is taken at setup and held through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (paddr == `FBM_OFF_MODE) begin
        prdata <= {30'h0, mode_q};
      end else if (paddr == `FBM_OFF_PRESET) begin
        prdata <= {24'h0, preset_q};
      end else if (paddr == `FBM_OFF_ADDR) begin
        prdata <= {18'h0, addr1_q, 2'h0, addr0_q};
      end else if (paddr == `FBM_OFF_CMD) begin
        prdata <= {13'h0000, scaling_code, quick_stop_ovr, coast_stop, run_on, op_enable_grant,
                   setpoint_ai, run_ccw, run_cw, fixed_speed_sel, 4'h0};
      end else if (paddr == `FBM_OFF_STAT) begin
        prdata <= {24'h0, loc_q, 1'b0, slave2_visible, slave1_active, rx_done_q};
      end else if (paddr == `FBM_OFF_SER_TX) begin
        prdata <= ser_tx_q;
      end else if (paddr == `FBM_OFF_SER_RX) begin
        prdata <= ser_rx_q;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // error answer for unmapped offsets, held through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      if (paddr == `FBM_OFF_MODE || paddr == `FBM_OFF_PRESET || paddr == `FBM_OFF_ADDR ||
          paddr == `FBM_OFF_CMD || paddr == `FBM_OFF_STAT || paddr == `FBM_OFF_SER_TX ||
          paddr == `FBM_OFF_SER_RX) begin
        pslverr <= 1'b0;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** hdl/fbm_regs.vh ***
// register offsets, field positions, reset values and codes of the fieldbus slave bit mapper
`ifndef FBM_REGS_VH
`define FBM_REGS_VH
`define FBM_OFF_MODE 12'h000
`define FBM_OFF_PRESET 12'h004
`define FBM_OFF_ADDR 12'h008
`define FBM_OFF_CMD 12'h00C
`define FBM_OFF_STAT 12'h010
`define FBM_OFF_SER_TX 12'h014
`define FBM_OFF_SER_RX 12'h018
`define FBM_MODE_SINGLE 2'h0
`define FBM_MODE_DUAL 2'h2
`define FBM_RST_MODE 2'h0
`define FBM_PRESET_30 8'h1E
`define FBM_PRESET_31 8'h1F
`define FBM_PRESET_32 8'h20
`define FBM_PRESET_34 8'h22
`define FBM_RST_PRESET 8'h1E
`define FBM_RST_ADDR 6'h00
`define FBM_ADDR_A_MAX 6'h1F
`define FBM_ADDR_BAD 6'h20
`define FBM_ADDR0_LSB 0
`define FBM_ADDR1_LSB 8
`define FBM_STAT_RXDONE 0
`define FBM_STAT_S1ACT 1
`define FBM_STAT_S2VIS 2
`define FBM_STAT_LOCAL_LSB 4
`define FBM_SER_BITS 6'h20
`endif
